// ==== hdl/dsl_sequencer.sv ====
// Purpose: host that runs the converter clock and link start-up sequence
// Assumes: device register port is a req/ack handshake on ref_clk
// Notes: software starts and watches the run through three apb words
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module dsl_sequencer
    import dsl_pkg::*;
#(
    parameter int unsigned PAUSE_CYCLES = PAUSE_CYC
)
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output dsl_dev_cmd_t dev_cmd,
    output logic dev_req,
    input wire logic dev_ack,
    input wire logic [7:0] dev_rdata
);
    // sequencer states, gray along fetch-exec-wait
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_EXEC = 3'b011,
        ST_WAIT = 3'b010,
        ST_PAUSE = 3'b110
    } dsl_state_t;

    dsl_state_t state_q; // sequencer state
    logic [4:0] idx_q; // current step index
    dsl_step_t step_q; // step fetched from memory
    logic [31:0] pause_cnt_q; // cycles spent in pause
    logic [8:0] ctrl_q; // control fields, start bit unused
    logic [19:0] cfg_q; // link mode, interpolation, sync duration
    logic done_q; // sticky run finished
    logic err_q; // sticky run failed
    logic [2:0] err_code_q; // cause of failure
    logic pready_q; // apb access answer
    logic pslverr_q; // apb unmapped access
    logic [31:0] prdata_q; // apb read data
    dsl_dev_cmd_t cmd_q; // device request fields
    logic req_q; // device request pending
    logic busy; // sequence running
    logic apb_wr; // apb write takes effect
    logic start; // accepted start order
    logic [7:0] step_data; // resolved write byte

    // output wiring, all from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign dev_cmd = cmd_q;
    assign dev_req = req_q;

    // common strobes
    assign busy = (state_q != ST_IDLE);
    assign apb_wr = psel && penable && pwrite && pready_q;
    assign start = apb_wr && (paddr == APB_CTRL) && pwdata[CTRL_START] && !busy;

    // address decode used by the error answer only
    function automatic logic apb_mapped(input logic [11:0] a);
        apb_mapped = (a == APB_CTRL) || (a == APB_CFG) || (a == APB_STATUS);
    endfunction

    // write byte of a step from its source and the software settings
    always_comb begin
        case (step_q.src)
            SRC_DIV: step_data = {6'h00, ctrl_q[CTRL_DIV3], ctrl_q[CTRL_DIV2]};
            SRC_SRCH_A: step_data = ctrl_q[CTRL_FAST] ? VAL_SRCH_A_FAST : VAL_SRCH_A_SLOW;
            SRC_SRCH_B: step_data = ctrl_q[CTRL_FAST] ? VAL_SRCH_B_FAST : VAL_SRCH_B_SLOW;
            SRC_MODE: step_data = {2'b00, cfg_q[5:0]};
            SRC_INTERP: step_data = cfg_q[15:8];
            // powerdown forced low under subclass 1
            SRC_SYSREF: step_data = {1'b0, ctrl_q[CTRL_DC], 5'h00,
                                     ctrl_q[CTRL_SRPD] & ~ctrl_q[CTRL_SUB1]};
            SRC_SYNC: step_data = {cfg_q[19:16], 4'h0};
            default: step_data = step_q.data;
        endcase
    end

    // apb answer: ready in the first access cycle, zero wait
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel && !penable && !pready_q;
            pslverr_q <= psel && !penable && !apb_mapped(paddr);
        end
    end

    // apb read data, captured in the setup cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prdata_q <= 32'h00000000;
        end else if (psel && !penable) begin
            case (paddr)
                APB_CTRL: prdata_q <= {23'h000000, ctrl_q};
                APB_CFG: prdata_q <= {12'h000, cfg_q};
                // busy 0, done 1, error 2, code 6:4, step index 12:8
                APB_STATUS: prdata_q <= {19'h00000, idx_q, 1'b0, err_code_q, 1'b0, err_q, done_q, busy};
                default: prdata_q <= 32'h00000000;
            endcase
        end
    end

    // settings, frozen while a run is going
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_q <= CTRL_RESET;
            cfg_q <= CFG_RESET;
        end else if (apb_wr && !busy) begin
            if (paddr == APB_CTRL) begin
                ctrl_q <= {pwdata[8:1], 1'b0};
            end
            if (paddr == APB_CFG) begin
                cfg_q <= pwdata[19:0];
            end
        end
    end

    // sequence memory
    dsl_step_rom u_rom (
        .ref_clk(ref_clk),
        .idx(idx_q),
        .step_q(step_q)
    );

    // step walker
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            idx_q <= 5'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // both divider bits set never runs
                    if (start && !(pwdata[CTRL_DIV2] && pwdata[CTRL_DIV3])) begin
                        idx_q <= pwdata[CTRL_BYPASS] ? STEP_DLL_FIRST : STEP_PLL_FIRST;
                        state_q <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    state_q <= ST_EXEC;
                end
                ST_EXEC: begin
                    case (step_q.op)
                        OP_WR, OP_RD_ONE, OP_RD_OK7: state_q <= ST_WAIT;
                        OP_PAUSE: state_q <= ST_PAUSE;
                        default: state_q <= ST_IDLE;
                    endcase
                end
                ST_WAIT: begin
                    // next step only after the device answers
                    if (dev_ack) begin
                        if ((step_q.op == OP_RD_ONE && !dev_rdata[LOCK_BIT]) ||
                            (step_q.op == OP_RD_OK7 && dev_rdata[INVALID_BIT])) begin
                            state_q <= ST_IDLE;
                        end else begin
                            idx_q <= idx_q + 5'h01;
                            state_q <= ST_FETCH;
                        end
                    end
                end
                ST_PAUSE: begin
                    if (pause_cnt_q == PAUSE_CYCLES - 1) begin
                        idx_q <= idx_q + 5'h01;
                        state_q <= ST_FETCH;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // pause counter on ref_clk
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pause_cnt_q <= 32'h00000000;
        end else if (state_q == ST_PAUSE) begin
            pause_cnt_q <= pause_cnt_q + 32'h00000001;
        end else begin
            pause_cnt_q <= 32'h00000000;
        end
    end

    // device request, held until acknowledged
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            req_q <= 1'b0;
            cmd_q <= '0;
        end else if (state_q == ST_EXEC && (step_q.op == OP_WR || step_q.op == OP_RD_ONE ||
                                            step_q.op == OP_RD_OK7)) begin
            req_q <= 1'b1;
            cmd_q <= '{(step_q.op == OP_WR), step_q.addr, (step_q.op == OP_WR) ? step_data : 8'h00};
        end else if (dev_ack) begin
            req_q <= 1'b0;
        end
    end

    // sticky run flags, cleared by the next accepted start, which sets the error when both divider bits are set
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            done_q <= 1'b0;
            err_q <= 1'b0;
            err_code_q <= ERR_NONE;
        end else if (start) begin
            done_q <= 1'b0;
            err_q <= pwdata[CTRL_DIV2] && pwdata[CTRL_DIV3];
            err_code_q <= (pwdata[CTRL_DIV2] && pwdata[CTRL_DIV3]) ? ERR_DIV : ERR_NONE;
        end else if (state_q == ST_EXEC && step_q.op == OP_END) begin
            done_q <= 1'b1;
        end else if (state_q == ST_WAIT && dev_ack) begin
            if (step_q.op == OP_RD_ONE && !dev_rdata[LOCK_BIT]) begin
                err_q <= 1'b1;
                err_code_q <= (step_q.addr == REG_PLL_LOCK_STATUS) ? ERR_PLL : ERR_DLL;
            end else if (step_q.op == OP_RD_OK7 && dev_rdata[INVALID_BIT]) begin
                err_q <= 1'b1;
                err_code_q <= ERR_MODE;
            end
        end
    end

    // helper: cycles from the last vco write answer to the next request
    logic [31:0] gap_q;
    logic vco_last_q;
    logic req_d1_q;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gap_q <= 32'h00000000;
            vco_last_q <= 1'b0;
            req_d1_q <= 1'b0;
        end else begin
            req_d1_q <= req_q;
            if (dev_ack && req_q) begin
                gap_q <= 32'h00000000;
                vco_last_q <= (cmd_q.addr == REG_VCO_RESET_CONTROL) && cmd_q.we;
            end else if (!req_q) begin
                gap_q <= gap_q + 32'h00000001;
            end
        end
    end

    // divider write keeps the upper six bits clear
    property p_div_upper;
        @(posedge ref_clk) disable iff (srst)
        (req_q && cmd_q.we && cmd_q.addr == REG_PLL_OUTPUT_DIVIDER) |-> (cmd_q.wdata[7:2] == 6'h00);
    endproperty
    a_div_upper: assert property (p_div_upper) else $error("divider upper bits not zero");

    // divider write never sets both select bits
    property p_div_both;
        @(posedge ref_clk) disable iff (srst)
        (req_q && cmd_q.we && cmd_q.addr == REG_PLL_OUTPUT_DIVIDER) |-> !(&cmd_q.wdata[1:0]);
    endproperty
    a_div_both: assert property (p_div_both) else $error("divider bits both set");

    // request after the vco release waits the full pause
    property p_pause_len;
        @(posedge ref_clk) disable iff (srst)
        ($rose(req_q) && vco_last_q && cmd_q.addr == REG_PLL_LOCK_STATUS) |-> (gap_q >= PAUSE_CYCLES);
    endproperty
    a_pause_len: assert property (p_pause_len) else $error("pause after vco reset too short");

    // failed lock readback stops the run within two cycles
    property p_lock_fail;
        @(posedge ref_clk) disable iff (srst)
        (state_q == ST_WAIT && dev_ack && step_q.op == OP_RD_ONE && !dev_rdata[LOCK_BIT])
        |=> (state_q == ST_IDLE && err_q) ##1 !req_q;
    endproperty
    a_lock_fail: assert property (p_lock_fail) else $error("lock failure not stopping run");

    // search bytes match the clock speed setting
    property p_search;
        @(posedge ref_clk) disable iff (srst)
        (req_q && cmd_q.we && cmd_q.addr == REG_DELAY_LOOP_SEARCH) |->
        (ctrl_q[CTRL_FAST] ? (cmd_q.wdata == VAL_SRCH_A_FAST || cmd_q.wdata == VAL_SRCH_B_FAST)
                           : (cmd_q.wdata == VAL_SRCH_A_SLOW || cmd_q.wdata == VAL_SRCH_B_SLOW));
    endproperty
    a_search: assert property (p_search) else $error("wrong search byte");

    // sysref powerdown stays clear under subclass 1
    property p_sysref_receiver_powerdown;
        @(posedge ref_clk) disable iff (srst)
        (req_q && cmd_q.we && cmd_q.addr == REG_SYSREF_CONFIG && ctrl_q[CTRL_SUB1]) |-> !cmd_q.wdata[0];
    endproperty
    a_sysref_receiver_powerdown: assert property (p_sysref_receiver_powerdown) else $error("sysref powered down under subclass 1");

    // sync duration lands in the upper nibble
    property p_sync;
        @(posedge ref_clk) disable iff (srst)
        (req_q && cmd_q.we && cmd_q.addr == REG_SYNC_ERROR_CONFIG) |-> (cmd_q.wdata == {cfg_q[19:16], 4'h0});
    endproperty
    a_sync: assert property (p_sync) else $error("sync duration misplaced");

    // bypass never touches the vco reset register
    property p_bypass;
        @(posedge ref_clk) disable iff (srst)
        (req_q && ctrl_q[CTRL_BYPASS]) |-> (cmd_q.addr != REG_VCO_RESET_CONTROL && cmd_q.addr != REG_PLL_OUTPUT_DIVIDER);
    endproperty
    a_bypass: assert property (p_bypass) else $error("pll step issued in bypass");

    // request fields hold until answered
    property p_hold;
        @(posedge ref_clk) disable iff (srst)
        (req_q && !dev_ack) |=> (req_q && $stable(cmd_q));
    endproperty
    a_hold: assert property (p_hold) else $error("request changed before answer");

    // main scenarios
    c_done: cover property (@(posedge ref_clk) disable iff (srst) $rose(done_q));
    c_err: cover property (@(posedge ref_clk) disable iff (srst) $rose(err_q));
    c_pause: cover property (@(posedge ref_clk) disable iff (srst) state_q == ST_PAUSE);
    c_bypass_done: cover property (@(posedge ref_clk) disable iff (srst) $rose(done_q) && ctrl_q[CTRL_BYPASS]);
endmodule

// ==== hdl/dsl_pkg.sv ====
// Purpose: shared types and constants of the converter start-up sequencer
// Assumes: 40 MHz ref_clk, 12-bit device register addresses, 8-bit device data
// Notes: apb offsets are byte addresses of 32-bit words
package dsl_pkg;
    // step operations held in the sequence memory
    typedef enum logic [2:0] {
        OP_WR = 3'h0,      // write a data byte
        OP_RD_ONE = 3'h1,  // read, bit 0 must be one
        OP_RD_OK7 = 3'h2,  // read, bit 7 must be zero
        OP_PAUSE = 3'h3,   // timed pause
        OP_END = 3'h4      // sequence finished
    } dsl_op_t;
    // where the write data of a step comes from
    typedef enum logic [2:0] {
        SRC_CONST = 3'h0,
        SRC_DIV = 3'h1,
        SRC_SRCH_A = 3'h2,
        SRC_SRCH_B = 3'h3,
        SRC_MODE = 3'h4,
        SRC_INTERP = 3'h5,
        SRC_SYSREF = 3'h6,
        SRC_SYNC = 3'h7
    } dsl_src_t;
    // one entry of the sequence memory
    typedef struct packed {
        dsl_op_t op;
        dsl_src_t src;
        logic [11:0] addr;
        logic [7:0] data;
    } dsl_step_t;
    // request toward the device register port
    typedef struct packed {
        logic we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } dsl_dev_cmd_t;
    // device register addresses
    localparam logic [11:0] REG_CAL_SETTING_A = 12'h050;
    localparam logic [11:0] REG_CAL_SETTING_B = 12'h051;
    localparam logic [11:0] REG_CAL_CONTROL_A = 12'h061;
    localparam logic [11:0] REG_CAL_CONTROL_B = 12'h081;
    localparam logic [11:0] REG_SYSREF_CONFIG = 12'h084;
    localparam logic [11:0] REG_PLL_OUTPUT_DIVIDER = 12'h094;
    localparam logic [11:0] REG_DELAY_LINE_POWER = 12'h0c0;
    localparam logic [11:0] REG_DELAY_LOOP_SEARCH = 12'h0c1;
    localparam logic [11:0] REG_DELAY_LOOP_LOCK_STATUS = 12'h0c3;
    localparam logic [11:0] REG_DELAY_LOOP_STATUS_ENABLE = 12'h0c7;
    localparam logic [11:0] REG_DELAY_LOOP_UPDATE = 12'h0db;
    localparam logic [11:0] REG_DATAPATH_CLOCK_POWER = 12'h100;
    localparam logic [11:0] REG_LINK_MODE_SELECT = 12'h110;
    localparam logic [11:0] REG_INTERPOLATION_SELECT = 12'h111;
    localparam logic [11:0] REG_SYNC_ERROR_CONFIG = 12'h312;
    localparam logic [11:0] REG_VCO_RESET_CONTROL = 12'h792;
    localparam logic [11:0] REG_PLL_LOCK_STATUS = 12'h7b5;
    // constant data bytes
    localparam logic [7:0] VAL_ZERO = 8'h00;
    localparam logic [7:0] VAL_ONE = 8'h01;
    localparam logic [7:0] VAL_VCO_RESET = 8'h02;
    localparam logic [7:0] VAL_CAL_A = 8'h2a;
    localparam logic [7:0] VAL_CAL_CTRL_A = 8'h68;
    localparam logic [7:0] VAL_CAL_B1 = 8'h82;
    localparam logic [7:0] VAL_CAL_B2 = 8'h83;
    localparam logic [7:0] VAL_CAL_CTRL_B = 8'h03;
    localparam logic [7:0] VAL_SRCH_A_SLOW = 8'h48;
    localparam logic [7:0] VAL_SRCH_A_FAST = 8'h68;
    localparam logic [7:0] VAL_SRCH_B_SLOW = 8'h49;
    localparam logic [7:0] VAL_SRCH_B_FAST = 8'h69;
    // readback bit positions
    localparam int LOCK_BIT = 0;
    localparam int INVALID_BIT = 7;
    // sequence memory layout
    localparam logic [4:0] STEP_PLL_FIRST = 5'h00;
    localparam logic [4:0] STEP_DLL_FIRST = 5'h05;
    // pause timing
    localparam int PAUSE_MS = 100;
    localparam int CLK_HZ = 40000000;
    localparam int PAUSE_CYC = PAUSE_MS * (CLK_HZ / 1000);
    // apb register offsets
    localparam logic [11:0] APB_CTRL = 12'h000;
    localparam logic [11:0] APB_CFG = 12'h004;
    localparam logic [11:0] APB_STATUS = 12'h008;
    // control word fields
    localparam int CTRL_START = 0;
    localparam int CTRL_BYPASS = 1;
    localparam int CTRL_FAST = 2;
    localparam int CTRL_DIV2 = 4;
    localparam int CTRL_DIV3 = 5;
    localparam int CTRL_DC = 6;
    localparam int CTRL_SRPD = 7;
    localparam int CTRL_SUB1 = 8;
    localparam logic [8:0] CTRL_RESET = 9'h000;
    localparam logic [19:0] CFG_RESET = 20'h00000;
    // error codes
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_DIV = 3'h1;
    localparam logic [2:0] ERR_PLL = 3'h2;
    localparam logic [2:0] ERR_DLL = 3'h3;
    localparam logic [2:0] ERR_MODE = 3'h4;
endpackage

// ==== hdl/dsl_step_rom.sv ====
// Purpose: fixed start-up sequence, one step per index, registered read
// Assumes: index stable for one cycle before its step is used
// Notes: steps 0 to 4 belong to the pll and are skipped in bypass
`timescale 1ns/1ps
module dsl_step_rom
    import dsl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [4:0] idx,
    output dsl_step_t step_q
);
    // sequence content
    function automatic dsl_step_t rom_entry(input logic [4:0] i);
        case (i)
            5'h00: rom_entry = '{OP_WR, SRC_DIV, REG_PLL_OUTPUT_DIVIDER, VAL_ZERO};
            5'h01: rom_entry = '{OP_WR, SRC_CONST, REG_VCO_RESET_CONTROL, VAL_VCO_RESET};
            5'h02: rom_entry = '{OP_WR, SRC_CONST, REG_VCO_RESET_CONTROL, VAL_ZERO};
            5'h03: rom_entry = '{OP_PAUSE, SRC_CONST, 12'h000, VAL_ZERO};
            5'h04: rom_entry = '{OP_RD_ONE, SRC_CONST, REG_PLL_LOCK_STATUS, VAL_ZERO};
            5'h05: rom_entry = '{OP_WR, SRC_CONST, REG_DELAY_LINE_POWER, VAL_ZERO};
            5'h06: rom_entry = '{OP_WR, SRC_CONST, REG_DELAY_LOOP_UPDATE, VAL_ZERO};
            5'h07: rom_entry = '{OP_WR, SRC_CONST, REG_DELAY_LOOP_UPDATE, VAL_ONE};
            5'h08: rom_entry = '{OP_WR, SRC_CONST, REG_DELAY_LOOP_UPDATE, VAL_ZERO};
            5'h09: rom_entry = '{OP_WR, SRC_SRCH_A, REG_DELAY_LOOP_SEARCH, VAL_ZERO};
            5'h0a: rom_entry = '{OP_WR, SRC_SRCH_B, REG_DELAY_LOOP_SEARCH, VAL_ZERO};
            5'h0b: rom_entry = '{OP_WR, SRC_CONST, REG_DELAY_LOOP_STATUS_ENABLE, VAL_ONE};
            5'h0c: rom_entry = '{OP_RD_ONE, SRC_CONST, REG_DELAY_LOOP_LOCK_STATUS, VAL_ZERO};
            5'h0d: rom_entry = '{OP_WR, SRC_CONST, REG_CAL_SETTING_A, VAL_CAL_A};
            5'h0e: rom_entry = '{OP_WR, SRC_CONST, REG_CAL_CONTROL_A, VAL_CAL_CTRL_A};
            5'h0f: rom_entry = '{OP_WR, SRC_CONST, REG_CAL_SETTING_B, VAL_CAL_B1};
            5'h10: rom_entry = '{OP_WR, SRC_CONST, REG_CAL_SETTING_B, VAL_CAL_B2};
            5'h11: rom_entry = '{OP_WR, SRC_CONST, REG_CAL_CONTROL_B, VAL_CAL_CTRL_B};
            5'h12: rom_entry = '{OP_WR, SRC_CONST, REG_DATAPATH_CLOCK_POWER, VAL_ZERO};
            5'h13: rom_entry = '{OP_WR, SRC_MODE, REG_LINK_MODE_SELECT, VAL_ZERO};
            5'h14: rom_entry = '{OP_WR, SRC_INTERP, REG_INTERPOLATION_SELECT, VAL_ZERO};
            5'h15: rom_entry = '{OP_RD_OK7, SRC_CONST, REG_LINK_MODE_SELECT, VAL_ZERO};
            5'h16: rom_entry = '{OP_WR, SRC_SYSREF, REG_SYSREF_CONFIG, VAL_ZERO};
            5'h17: rom_entry = '{OP_WR, SRC_SYNC, REG_SYNC_ERROR_CONFIG, VAL_ZERO};
            default: rom_entry = '{OP_END, SRC_CONST, 12'h000, VAL_ZERO};
        endcase
    endfunction

    // registered read port
    always_ff @(posedge ref_clk) begin
        step_q <= rom_entry(idx);
    end
endmodule

// ==== testbench/dsl_dev_model.sv ====
// Purpose: behavioural converter register port answering the sequencer
// Assumes: one access outstanding, ack after slow idle cycles
// Notes: log_q keeps every access so the bench can check order
`timescale 1ns/1ps
module dsl_dev_model
    import dsl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input dsl_dev_cmd_t dev_cmd,
    input wire logic dev_req,
    output logic dev_ack = 1'b0,
    output logic [7:0] dev_rdata = 8'h5a,
    input wire logic pll_ok,
    input wire logic dll_ok,
    input wire logic bad,
    input wire logic [3:0] slow
);
    logic [7:0] mem_q [0:4095]; // device register file
    logic [20:0] log_q [$]; // accesses in arrival order
    logic [7:0] rd; // read value of the current access
    int cnt; // idle cycles before answering
    // answer one access; read data toggles when not valid
    always @(posedge ref_clk) begin
        dev_ack <= 1'b0;
        dev_rdata <= ~dev_rdata;
        if (srst) begin
            cnt = 0;
        end else if (dev_req && !dev_ack) begin
            cnt++;
            if (cnt > slow) begin
                cnt = 0;
                case (dev_cmd.addr)
                    12'h7b5: rd = {7'h00, pll_ok};
                    12'h0c3: rd = {7'h00, dll_ok};
                    12'h110: rd = {bad, mem_q[12'h110][6:0]};
                    default: rd = mem_q[dev_cmd.addr];
                endcase
                // settings stored as written
                if (dev_cmd.we) mem_q[dev_cmd.addr] <= dev_cmd.wdata;
                if (!dev_cmd.we) dev_rdata <= rd;
                log_q.push_back(dev_cmd);
                dev_ack <= 1'b1;
            end
        end
    end
endmodule

// ==== testbench/tb_dsl_sequencer.sv ====
// Purpose: self-checking bench of the start-up sequencer
// Assumes: short pause parameter, apb master per the slave contract
// Notes: expected access lists are built from the settings written
`timescale 1ns/1ps
module tb_dsl_sequencer;
    import dsl_pkg::*;
    logic ref_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pll_ok = 1'b1, dll_ok = 1'b1, bad = 1'b0, pready, pslverr, dev_req, dev_ack, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic [3:0] slow = 4'h3;
    logic [7:0] dev_rdata;
    dsl_dev_cmd_t dev_cmd;
    logic [20:0] ex [0:22]; // full expected access list
    int fails = 0, total_checks = 0;
    always #12.5 ref_clk = ~ref_clk;
    dsl_sequencer #(.PAUSE_CYCLES(20)) DUT (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dev_cmd(dev_cmd), .dev_req(dev_req), .dev_ack(dev_ack), .dev_rdata(dev_rdata));
    dsl_dev_model dev (.ref_clk(ref_clk), .srst(srst), .dev_cmd(dev_cmd), .dev_req(dev_req), .dev_ack(dev_ack),
        .dev_rdata(dev_rdata), .pll_ok(pll_ok), .dll_ok(dll_ok), .bad(bad), .slow(slow));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // start a run with control c, check status and accesses first..last
    task run(input string nm, input logic [8:0] c, input logic [2:0] code, input int first, input int last);
        int n;
        ex = '{{13'h1094, 6'h0, c[5:4]}, 21'h179202, 21'h179200, 21'h07b500, 21'h10c000, 21'h10db00,
            21'h10db01, 21'h10db00, {13'h10c1, c[2] ? 8'h68 : 8'h48}, {13'h10c1, c[2] ? 8'h69 : 8'h49},
            21'h10c701, 21'h00c300, 21'h10502a, 21'h106168, 21'h105182, 21'h105183, 21'h108103,
            21'h110000, 21'h111025, 21'h111142, 21'h011000, {13'h1084, 1'b0, c[6], 5'h0, c[7] & ~c[8]},
            21'h1312a0};
        dev.log_q.delete();
        apb(1'b1, APB_CFG, 32'h000a4225);
        apb(1'b1, APB_CTRL, {23'h0, c} | 32'h1);
        n = 0;
        do begin
            apb(1'b0, APB_STATUS, 32'h0);
            n++;
        end while (rdv[0] === 1'b1 && n < 3000);
        chk(rdv[6:4], code);
        chk(rdv[2:1], code == 3'h0 ? 2'b01 : 2'b10);
        chk(dev.log_q.size(), last - first + 1);
        for (int i = first; i <= last && i - first < dev.log_q.size(); i++) chk(dev.log_q[i - first], ex[i]);
        apb(1'b0, APB_CTRL, 32'h0);
        chk(rdv, {23'h0, c});
        $display("test %s finished", nm);
    endtask
    task t_regs;
        apb(1'b0, APB_CTRL, 32'h0);
        chk(rdv, 32'h0);
        apb(1'b0, APB_CFG, 32'h0);
        chk(rdv, 32'h0);
        apb(1'b1, 12'h00c, 32'hffffffff);
        chk(err, 1'b1);
        apb(1'b0, 12'h00c, 32'h0);
        chk(err, 1'b1);
        chk(rdv, 32'h0);
        $display("test regs finished");
    endtask
    task t_pll_slow;
        run("pll_slow", 9'h1e0, ERR_NONE, 0, 22);
    endtask
    task t_bypass_fast;
        slow <= 4'h0;
        run("bypass_fast", 9'h086, ERR_NONE, 4, 22);
    endtask
    task t_div_both;
        run("div_both", 9'h030, ERR_DIV, 0, -1);
    endtask
    task t_lock_fail;
        pll_ok <= 1'b0;
        run("pll_fail", 9'h010, ERR_PLL, 0, 3);
        {pll_ok, dll_ok} <= 2'b10;
        run("dll_fail", 9'h002, ERR_DLL, 4, 11);
        {dll_ok, bad} <= 2'b11;
        run("bad_combo", 9'h002, ERR_MODE, 4, 20);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        t_regs();
        t_pll_slow();
        t_bypass_fast();
        t_div_both();
        t_lock_fail();
        give_verdict();
    end
    // cut a hang short
    initial begin
        #(25 * 60000);
        fails++;
        give_verdict();
    end
endmodule
